/* pscu_cmd_unit.v */
/*
 * pump serial command unit: takes received characters, frames and checks
 * commands, decides on broadcast, replies ack/nak and the answer, resends
 * the answer on nak, and drives pump operation strobes.
 * assumes: a uart beside it delivers rx bytes as one-cycle strobes and
 * accepts tx bytes with a ready; one 100 MHz clock.
 */
// What this block does
// - all units act on broadcast start/stop, each only if its port is the operation port
// - never reply to a broadcast command
// - broadcast frame order fixed, ending LRC
// - broadcast value 1 start, 2 stop
// - operation parameter is two hex characters
// - return ack or nak within two seconds
// - drop partial command after five seconds
// - nak within 1500 ms resends answer
// - ignore command that breaks ack sequence
// - decode prefix plus function character
// - operations only from operation port
// - answer hash when ok, else error
// - query starts question mark then function
`timescale 1ns/100ps
`default_nettype none
`include "pscu_defines.vh"

module pscu_cmd_unit #(
	parameter        MS_CYCLES   = `PSCU_CLK_HZ / 1000,  // clocks per ms
	parameter [15:0] REPLY_MS    = `PSCU_T_REPLY_MS,     // reply deadline
	parameter [15:0] ABANDON_MS  = `PSCU_T_ABANDON_MS,   // partial frame limit
	parameter [15:0] RESEND_MS   = `PSCU_T_RESEND_MS,    // nak resend window
	parameter [7:0]  STATION_HI  = 8'h30,                // own frame number high
	parameter [7:0]  STATION_LO  = 8'h31                 // own frame number low
)(
	input  wire       clk_in,        // system clock
	input  wire       rstn_in,       // async reset, active low
	input  wire [7:0] rx_data_in,    // received byte
	input  wire       rx_valid_in,   // received byte strobe
	input  wire       oper_port_in,  // this port is the operation port
	input  wire [15:0] speed_in,     // measured speed, hz
	input  wire       tx_ready_in,   // uart can take a byte
	output reg  [7:0] tx_data_out,   // byte to send
	output reg        tx_valid_out,  // send strobe
	output reg        start_out,     // start pulse
	output reg        stop_out,      // stop pulse
	output reg        reset_out,     // fault reset pulse
	output reg        abandon_out    // partial frame dropped pulse
);

	// receive states
	localparam [2:0] S_IDLE = 3'h0, S_FN1 = 3'h1, S_FN2 = 3'h2, S_STX = 3'h3,
		S_BODY = 3'h4, S_LRC = 3'h5;
	// answer states
	localparam [1:0] A_IDLE = 2'h0, A_ACK = 2'h1, A_WAIT = 2'h2, A_SEND = 2'h3;
	localparam       ANS_MAX = 16; // answer buffer length

	// hex digit to nibble
	function [3:0] hex_val;
		input [7:0] c;
		begin
			hex_val = (c >= 8'h41) ? c[3:0] + 4'h9 : c[3:0];
		end
	endfunction

	// nibble to hex digit
	function [7:0] hex_chr;
		input [3:0] n;
		begin
			hex_chr = (n > 4'h9) ? {4'h4, n - 4'h9} : {4'h3, n};
		end
	endfunction

	reg [7:0]  rxd1_ff, rxd2_ff;      // rx data synchroniser
	reg        rxv1_ff, rxv2_ff;      // rx strobe synchroniser
	reg        rxv3_ff;               // strobe edge history
	reg [2:0]  rst_ff;                // receive state
	reg [1:0]  ast_ff;                // answer state
	reg        bcast_ff;              // frame number was zero
	reg        mine_ff;               // frame number matches
	reg [7:0]  lrc_ff;                // running LRC
	reg [4:0]  bidx_ff;               // body character index
	reg [7:0]  pre_ff, fn_ff;         // prefix and function
	reg [7:0]  p0_ff, p1_ff;          // parameter characters
	reg [15:0] tmr_ff;                // frame timer in ms
	reg [15:0] rsp_ff;                // reply or resend timer in ms
	reg [7:0]  ans_mem [0:ANS_MAX-1]; // answer buffer
	reg [4:0]  alen_ff, aptr_ff;      // answer length, send pointer
	reg [7:0]  ack_ff;                // pending ack or nak
	reg        busy_ff;               // answer being sent
	wire       ms_tick;               // millisecond enable
	wire       rx_stb = rxv2_ff & ~rxv3_ff; // one strobe per byte
	wire [7:0] rxc = rxd2_ff;        // synchronised byte
	integer    i;

	pscu_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.tick_out (ms_tick)
	);

	// two flops on the incoming byte and strobe
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rxd1_ff <= 8'h00;
			rxd2_ff <= 8'h00;
			rxv1_ff <= 1'b0;
			rxv2_ff <= 1'b0;
			rxv3_ff <= 1'b0;
		end
		else
		begin
			rxd1_ff <= rx_data_in;
			rxd2_ff <= rxd1_ff;
			rxv1_ff <= rx_valid_in;
			rxv2_ff <= rxv1_ff;
			rxv3_ff <= rxv2_ff;
		end
	end

	// receive parser, checker, dispatcher and answer sender
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_ff       <= S_IDLE;
			ast_ff       <= A_IDLE;
			bcast_ff     <= 1'b0;
			mine_ff      <= 1'b0;
			lrc_ff       <= 8'h00;
			bidx_ff      <= 5'h00;
			pre_ff       <= 8'h00;
			fn_ff        <= 8'h00;
			p0_ff        <= 8'h00;
			p1_ff        <= 8'h00;
			tmr_ff       <= 16'h0000;
			rsp_ff       <= 16'h0000;
			alen_ff      <= 5'h00;
			aptr_ff      <= 5'h00;
			ack_ff       <= 8'h00;
			busy_ff      <= 1'b0;
			tx_data_out  <= 8'h00;
			tx_valid_out <= 1'b0;
			start_out    <= 1'b0;
			stop_out     <= 1'b0;
			reset_out    <= 1'b0;
			abandon_out  <= 1'b0;
			for (i = 0; i < ANS_MAX; i = i + 1)
				ans_mem[i] <= 8'h00;
		end
		else
		begin
			tx_valid_out <= 1'b0;
			start_out    <= 1'b0;
			stop_out     <= 1'b0;
			reset_out    <= 1'b0;
			abandon_out  <= 1'b0;
			// frame timer runs only while a frame is open
			if (rst_ff != S_IDLE && ms_tick)
				tmr_ff <= tmr_ff + 16'h0001;
			if (ms_tick && rsp_ff != 16'h0000)
				rsp_ff <= rsp_ff - 16'h0001;
			// drop a frame that has run past the limit
			if (rst_ff != S_IDLE && tmr_ff >= ABANDON_MS)
			begin
				rst_ff      <= S_IDLE;
				tmr_ff      <= 16'h0000;
				abandon_out <= 1'b1;
			end
			else if (rx_stb)
			begin
				case (rst_ff)
					S_IDLE:
					begin
						// host control characters while an answer waits
						if (ast_ff == A_WAIT && rxc == `PSCU_CH_NAK && rsp_ff != 16'h0000)
						begin
							aptr_ff <= 5'h00;
							ast_ff  <= A_SEND;
						end
						else if (ast_ff == A_WAIT && rxc == `PSCU_CH_ACK)
							ast_ff <= A_IDLE;
						else if (rxc == `PSCU_CH_AT && !busy_ff && ast_ff != A_WAIT)
						begin
							rst_ff <= S_FN1;
							tmr_ff <= 16'h0000;
						end
					end
					S_FN1:
					begin
						bcast_ff <= (rxc == `PSCU_CH_ZERO);
						mine_ff  <= (rxc == STATION_HI);
						rst_ff   <= S_FN2;
					end
					S_FN2:
					begin
						bcast_ff <= bcast_ff & (rxc == `PSCU_CH_ZERO);
						mine_ff  <= mine_ff & (rxc == STATION_LO);
						rst_ff   <= S_STX;
					end
					S_STX:
					begin
						lrc_ff  <= 8'h00;
						bidx_ff <= 5'h00;
						rst_ff  <= (rxc == `PSCU_CH_STX) ? S_BODY : S_IDLE;
					end
					S_BODY:
					begin
						lrc_ff  <= lrc_ff ^ rxc;
						bidx_ff <= bidx_ff + 5'h01;
						// block digits 0..2, prefix 3, function 4, parameter 5..6
						case (bidx_ff)
							5'h03: pre_ff <= rxc;
							5'h04: fn_ff  <= rxc;
							5'h05: p0_ff  <= rxc;
							5'h06: p1_ff  <= rxc;
							default: ;
						endcase
						if (rxc == `PSCU_CH_ETX)
							rst_ff <= S_LRC;
						else if (bidx_ff == 5'h1f)
							rst_ff <= S_IDLE;
					end
					S_LRC:
					begin
						rst_ff <= S_IDLE;
						tmr_ff <= 16'h0000;
						if (bcast_ff)
						begin
							// broadcast: act silently, only start or stop
							if (rxc == lrc_ff && pre_ff == `PSCU_CH_SP && fn_ff == `PSCU_FN_OPER
								&& oper_port_in)
							begin
								start_out <= ({hex_val(p0_ff), hex_val(p1_ff)} == `PSCU_OP_START);
								stop_out  <= ({hex_val(p0_ff), hex_val(p1_ff)} == `PSCU_OP_STOP);
							end
						end
						else if (mine_ff)
						begin
							ack_ff <= (rxc == lrc_ff) ? `PSCU_CH_ACK : `PSCU_CH_NAK;
							ast_ff <= A_ACK;
							rsp_ff <= REPLY_MS;
							if (rxc == lrc_ff)
							begin
								// build answer: @ F1 F2 stx 0 0 1 body etx lrc
								ans_mem[0] <= `PSCU_CH_AT;
								ans_mem[1] <= STATION_HI;
								ans_mem[2] <= STATION_LO;
								ans_mem[3] <= `PSCU_CH_STX;
								ans_mem[4] <= `PSCU_CH_ZERO;
								ans_mem[5] <= `PSCU_CH_ZERO;
								ans_mem[6] <= `PSCU_CH_ONE;
								if (pre_ff == `PSCU_CH_QM && fn_ff == `PSCU_FN_SPEED)
								begin
									ans_mem[7]  <= `PSCU_CH_SP;
									ans_mem[8]  <= fn_ff;
									ans_mem[9]  <= hex_chr(speed_in[15:12]);
									ans_mem[10] <= hex_chr(speed_in[11:8]);
									ans_mem[11] <= hex_chr(speed_in[7:4]);
									ans_mem[12] <= hex_chr(speed_in[3:0]);
									ans_mem[13] <= `PSCU_CH_ETX;
									ans_mem[14] <= 8'h00 ^ 8'h30 ^ 8'h30 ^ 8'h31 ^ `PSCU_CH_SP ^ fn_ff
										^ hex_chr(speed_in[15:12]) ^ hex_chr(speed_in[11:8])
										^ hex_chr(speed_in[7:4]) ^ hex_chr(speed_in[3:0])
										^ `PSCU_CH_ETX;
									alen_ff <= 5'd15;
								end
								else if (pre_ff == `PSCU_CH_SP && fn_ff == `PSCU_FN_OPER && oper_port_in)
								begin
									start_out  <= ({hex_val(p0_ff), hex_val(p1_ff)} == `PSCU_OP_START);
									stop_out   <= ({hex_val(p0_ff), hex_val(p1_ff)} == `PSCU_OP_STOP);
									reset_out  <= ({hex_val(p0_ff), hex_val(p1_ff)} == `PSCU_OP_RESET);
									ans_mem[7] <= `PSCU_CH_HASH;
									ans_mem[8] <= `PSCU_CH_ETX;
									ans_mem[9] <= 8'h30 ^ 8'h30 ^ 8'h31 ^ `PSCU_CH_HASH ^ `PSCU_CH_ETX;
									alen_ff    <= 5'd10;
								end
								else
								begin
									// unknown or refused: error mark plus code 001
									ans_mem[7]  <= `PSCU_CH_EXCL;
									ans_mem[8]  <= `PSCU_CH_ZERO;
									ans_mem[9]  <= `PSCU_CH_ZERO;
									ans_mem[10] <= `PSCU_CH_ONE;
									ans_mem[11] <= `PSCU_CH_ETX;
									ans_mem[12] <= 8'h30 ^ 8'h30 ^ 8'h31 ^ `PSCU_CH_EXCL ^ 8'h30 ^ 8'h30
										^ 8'h31 ^ `PSCU_CH_ETX;
									alen_ff     <= 5'd13;
								end
							end
							else
								alen_ff <= 5'h00;
						end
					end
					default: rst_ff <= S_IDLE;
				endcase
			end
			// transmit side
			case (ast_ff)
				A_ACK:
				begin
					if (tx_ready_in && !tx_valid_out)
					begin
						tx_data_out  <= ack_ff;
						tx_valid_out <= 1'b1;
						aptr_ff      <= 5'h00;
						ast_ff       <= (alen_ff == 5'h00) ? A_IDLE : A_SEND;
					end
				end
				A_SEND:
				begin
					busy_ff <= 1'b1;
					if (tx_ready_in && !tx_valid_out)
					begin
						tx_data_out  <= ans_mem[aptr_ff[3:0]];
						tx_valid_out <= 1'b1;
						aptr_ff      <= aptr_ff + 5'h01;
						if (aptr_ff + 5'h01 == alen_ff)
						begin
							ast_ff  <= A_WAIT;
							busy_ff <= 1'b0;
							rsp_ff  <= RESEND_MS;
						end
					end
				end
				A_WAIT:
				begin
					if (rsp_ff == 16'h0000)
						ast_ff <= A_IDLE;
				end
				default: ;
			endcase
		end
	end

endmodule // pscu_cmd_unit

`default_nettype wire

/* pscu_defines.vh */
/*
 * shared constants for the pump serial command unit: character codes,
 * command letters, operation values and timing figures.
 * assumes: included by bare name into plain verilog design files.
 */
`ifndef PSCU_DEFINES_VH
`define PSCU_DEFINES_VH

// framing characters
`define PSCU_CH_AT      8'h40
`define PSCU_CH_STX     8'h02
`define PSCU_CH_ETX     8'h03
`define PSCU_CH_ACK     8'h06
`define PSCU_CH_NAK     8'h15
`define PSCU_CH_SP      8'h20
`define PSCU_CH_QM      8'h3f
`define PSCU_CH_HASH    8'h23
`define PSCU_CH_EXCL    8'h21
`define PSCU_CH_ZERO    8'h30
`define PSCU_CH_ONE     8'h31
// function letters
`define PSCU_FN_OPER    8'h45
`define PSCU_FN_SPEED   8'h44
// operation values
`define PSCU_OP_START   8'h01
`define PSCU_OP_STOP    8'h02
`define PSCU_OP_RESET   8'h04
// timing figures in milliseconds
`define PSCU_T_REPLY_MS    2000
`define PSCU_T_ABANDON_MS  5000
`define PSCU_T_RESEND_MS   1500
`define PSCU_T_TURN_MS     1
// clock rate
`define PSCU_CLK_HZ        100000000

`endif

/* pscu_ms_tick.v */
/*
 * millisecond enable divider: one-cycle pulse every CYCLES clocks.
 * assumes: single clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pscu_ms_tick #(
	parameter CYCLES = 100000 // clocks per tick
)(
	input  wire clk_in,       // system clock
	input  wire rstn_in,      // async reset, active low
	output reg  tick_out      // one-cycle tick
);

	reg [31:0] cnt_ff; // cycle counter

	// count up to the tick
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt_ff   <= 32'h0000_0000;
			tick_out <= 1'b0;
		end
		else if (cnt_ff >= CYCLES - 1)
		begin
			cnt_ff   <= 32'h0000_0000;
			tick_out <= 1'b1;
		end
		else
		begin
			cnt_ff   <= cnt_ff + 32'h0000_0001;
			tick_out <= 1'b0;
		end
	end

endmodule // pscu_ms_tick

`default_nettype wire

/* pscu_cmd_props.sv */
/* checker for the pump serial command unit ports.
   assumes: bound onto pscu_cmd_unit, one clock, async low reset. */
`timescale 1ns/100ps
`default_nettype none
module pscu_cmd_props (
	input wire clk_in,       // system clock
	input wire rstn_in,      // async reset, active low
	input wire rx_valid_in,  // received byte strobe
	input wire oper_port_in, // operation port select
	input wire tx_ready_in,  // uart can take a byte
	input wire tx_valid_out, // send strobe
	input wire start_out,    // start pulse
	input wire stop_out,     // stop pulse
	input wire reset_out,    // fault reset pulse
	input wire abandon_out   // partial frame dropped
);
	reg [9:0] quiet_ff; // cycles since last rx byte, saturating
	// a reply needs a recent byte as its cause
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			quiet_ff <= 10'h3ff;
		else if (rx_valid_in)
			quiet_ff <= 10'h000;
		else if (quiet_ff != 10'h3ff)
			quiet_ff <= quiet_ff + 10'h001;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	chk_tx_single: assert property (tx_valid_out |=> !tx_valid_out)
		else $error("send strobe held two cycles");
	chk_tx_ready: assert property (tx_valid_out |-> $past(tx_ready_in))
		else $error("byte sent while uart not ready");
	chk_tx_caused: assert property (tx_valid_out |-> quiet_ff < 10'h258)
		else $error("byte sent with no recent request");
	chk_start_single: assert property (start_out |=> !start_out)
		else $error("start pulse too long");
	chk_op_onehot: assert property ($onehot0({start_out, stop_out, reset_out}))
		else $error("two operations at once");
	chk_op_port: assert property ((start_out | stop_out | reset_out) |-> oper_port_in)
		else $error("operation off the operation port");
	chk_reset_quiet: assert property (!$past(rstn_in) |-> !(tx_valid_out | start_out | stop_out))
		else $error("output active right after reset");
	chk_abandon_single: assert property (abandon_out |=> !abandon_out)
		else $error("drop pulse too long");
	cov_start: cover property (start_out);
	cov_stop: cover property (stop_out);
	cov_abandon: cover property (abandon_out);
endmodule // pscu_cmd_props
bind pscu_cmd_unit pscu_cmd_props i_props (
	.clk_in       (clk_in),
	.rstn_in      (rstn_in),
	.rx_valid_in  (rx_valid_in),
	.oper_port_in (oper_port_in),
	.tx_ready_in  (tx_ready_in),
	.tx_valid_out (tx_valid_out),
	.start_out    (start_out),
	.stop_out     (stop_out),
	.reset_out    (reset_out),
	.abandon_out  (abandon_out)
);
`default_nettype wire

/* pscu_host_model.sv */
/* host side model: feeds bytes to the unit, collects its replies.
   assumes: bench clock, host lines change at falling edges. */
`timescale 1ns/100ps
`default_nettype none
module pscu_host_model (
	input  wire       clk_in,       // bench clock
	input  wire [7:0] byte_in,      // byte from the unit
	input  wire       strobe_in,    // byte from the unit valid
	input  wire       slow_in,      // stall the reply path
	output reg        ready_out,    // host can take a byte
	output reg  [7:0] rx_data_out,  // byte towards the unit
	output reg        rx_valid_out  // byte towards the unit valid
);
	reg [1:0] cnt_ff = 2'h0; // stall phase
	reg [7:0] got_q[$];      // bytes seen from the unit
	initial
	begin
		ready_out = 1'b1;
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
	end
	// slow host takes one byte in four cycles
	always @(negedge clk_in)
	begin
		cnt_ff <= cnt_ff + 2'h1;
		ready_out <= !slow_in || cnt_ff == 2'h0;
	end
	// answer ends at etx plus one checksum byte
	always @(posedge clk_in)
		if (strobe_in)
			got_q.push_back(byte_in);
	// one byte, then a released line shows the inverse
	task send_byte(input [7:0] b);
	begin
		@(negedge clk_in);
		rx_data_out = b;
		rx_valid_out = 1'b1;
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		rx_data_out = ~b;
	end
	endtask
endmodule // pscu_host_model
`default_nettype wire

/* pump_serial_command_timing_tb.sv */
/* self-checking bench for the pump serial command unit.
   assumes: short ms tick (10 clocks), host model beside it. */
`timescale 1ns/100ps
`default_nettype none
module pump_serial_command_timing_tb;
	reg        clk_in;
	reg        rstn_in;
	reg        oper_port_in;
	reg [15:0] speed_in;
	reg        slow;
	wire [7:0] rx_data;
	wire [7:0] tx_data;
	wire       rx_valid, tx_valid, tx_ready, start, stop, rst_op, abandon;
	integer    seed, fail_count, checked, i, cyc, t0;
	reg [7:0]  cnt[0:3]; // seen pulses: start stop reset drop
	reg [7:0]  e[0:3];   // expected pulses
	reg [7:0]  q[$];     // frame sent
	reg [7:0]  a[$];     // first answer
	pscu_cmd_unit #(
		.MS_CYCLES  (32'h0000000a),
		.ABANDON_MS (16'h0014),
		.RESEND_MS  (16'h001e)
	) i_dut (
		.clk_in       (clk_in),
		.rstn_in      (rstn_in),
		.rx_data_in   (rx_data),
		.rx_valid_in  (rx_valid),
		.oper_port_in (oper_port_in),
		.speed_in     (speed_in),
		.tx_ready_in  (tx_ready),
		.tx_data_out  (tx_data),
		.tx_valid_out (tx_valid),
		.start_out    (start),
		.stop_out     (stop),
		.reset_out    (rst_op),
		.abandon_out  (abandon)
	);
	pscu_host_model i_host (
		.clk_in       (clk_in),
		.byte_in      (tx_data),
		.strobe_in    (tx_valid),
		.slow_in      (slow),
		.ready_out    (tx_ready),
		.rx_data_out  (rx_data),
		.rx_valid_out (rx_valid)
	);
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// pulse counters
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		cnt[0] <= cnt[0] + start;
		cnt[1] <= cnt[1] + stop;
		cnt[2] <= cnt[2] + rst_op;
		cnt[3] <= cnt[3] + abandon;
	end
	function [7:0] hx(input [3:0] n);
		hx = (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction
	task check(input [7:0] seen, input [7:0] exp);
	begin
		checked = checked + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task print_verdict;
	begin
		$display("checks %0d fails %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	// wait until the unit has been quiet for 80 cycles
	task settle;
		integer k, qt;
	begin
		qt = 0;
		for (k = 0; k < 3000 && qt < 80; k = k + 1)
		begin
			@(negedge clk_in);
			qt = tx_valid ? 0 : qt + 1;
		end
		if (qt < 80)
		begin
			fail_count = fail_count + 1;
			print_verdict;
		end
	end
	endtask
	// build, send and wait out a frame to station 0f2
	task frame(input [7:0] f2, input [7:0] pre, input [7:0] fn, input [7:0] par, input integer np,
		input [7:0] bad);
		reg [7:0] x;
		integer   j;
	begin
		q = {8'h40, 8'h30, f2, 8'h02, 8'h30, 8'h30, 8'h31, pre, fn};
		for (j = np - 1; j >= 0; j = j - 1)
			q.push_back(hx(par[4 * j +: 4]));
		q.push_back(8'h03);
		x = 8'h00;
		for (j = 4; j < q.size(); j = j + 1)
			x = x ^ q[j];
		q.push_back(x ^ bad);
		i_host.got_q.delete();
		for (j = 0; j < q.size(); j = j + 1)
			i_host.send_byte(q[j]);
		settle;
	end
	endtask
	// reply byte, then answer framing, checksum and tail
	task chk_ans(input [7:0] first, input [31:0] tail, input integer nt);
		reg [7:0] x;
		integer   j, n;
	begin
		n = i_host.got_q.size();
		check({7'h00, n > nt + 7}, 8'h01);
		if (n > nt + 7)
		begin
			check(i_host.got_q[0], first);
			check(i_host.got_q[n - 2], 8'h03);
			x = 8'h00;
			for (j = 5; j < n - 1; j = j + 1)
				x = x ^ i_host.got_q[j];
			check(i_host.got_q[n - 1], x);
			for (j = 0; j < nt; j = j + 1)
				check(i_host.got_q[n - 2 - nt + j], tail[8 * (nt - 1 - j) +: 8]);
		end
	end
	endtask
	task tend(input string nm);
		integer j;
	begin
		for (j = 0; j < 4; j = j + 1)
			check(cnt[j], e[j]);
		$display("end of %s, checks %0d, fails %0d", nm, checked, fail_count);
	end
	endtask
	initial
	begin
		seed = 32'h8da8ecce;
		fail_count = 0;
		checked = 0;
		cyc = 0;
		for (i = 0; i < 4; i = i + 1)
		begin
			cnt[i] = 8'h00;
			e[i] = 8'h00;
		end
		rstn_in = 1'b0;
		oper_port_in = 1'b1;
		speed_in = 16'h0000;
		slow = 1'b1;
		repeat (3) @(negedge clk_in);
		rstn_in = 1'b1;
		// speed query on a slow host, then a nak asks for it again
		speed_in = $random(seed);
		frame(8'h31, 8'h3f, 8'h44, 8'h00, 0, 8'h00);
		chk_ans(8'h06, {hx(speed_in[15:12]), hx(speed_in[11:8]), hx(speed_in[7:4]), hx(speed_in[3:0])}, 4);
		a = i_host.got_q;
		i_host.got_q.delete();
		i_host.send_byte(8'h15);
		settle;
		for (i = 1; i < a.size(); i = i + 1)
			check(i_host.got_q[i - 1], a[i]);
		i_host.send_byte(8'h06);
		tend("query");
		// partial frame is dropped after the limit
		t0 = cyc;
		for (i = 0; i < 4; i = i + 1)
			i_host.send_byte(q[i]);
		for (i = 0; i < 400 && cnt[3] === e[3]; i = i + 1)
			@(negedge clk_in);
		if (i == 400)
		begin
			fail_count = fail_count + 1;
			print_verdict;
		end
		check({7'h00, cyc - t0 >= 32'hbe && cyc - t0 <= 32'he6}, 8'h01);
		e[3] = e[3] + 1;
		// the host sends the dropped command again and is answered
		frame(8'h31, 8'h3f, 8'h44, 8'h00, 0, 8'h00);
		check(i_host.got_q[0], 8'h06);
		i_host.send_byte(8'h06);
		tend("abandon");
		// each operation on and off the operation port
		slow = $random(seed);
		for (i = 0; i < 6; i = i + 1)
		begin
			oper_port_in = i < 3;
			frame(8'h31, 8'h20, 8'h45, 8'h01 << (i % 3), 2, 8'h00);
			if (i < 3)
				chk_ans(8'h06, 32'h00000023, 1);
			e[i % 3] = e[i % 3] + (i < 3);
			i_host.send_byte(8'h06);
		end
		oper_port_in = 1'b1;
		tend("operations");
		// broadcast start and stop, never answered
		for (i = 0; i < 2; i = i + 1)
		begin
			frame(8'h30, 8'h20, 8'h45, 8'h01 << i, 2, 8'h00);
			check({7'h00, i_host.got_q.size() == 0}, 8'h01);
			e[i] = e[i] + 1;
		end
		tend("broadcast");
		// corrupted checksum gets nak and no action
		frame(8'h31, 8'h20, 8'h45, 8'h01, 2, 8'h5a);
		check(i_host.got_q[0], 8'h15);
		tend("checksum");
		// unknown function gets the error answer
		frame(8'h31, 8'h3f, 8'h5a, 8'h00, 0, 8'h00);
		chk_ans(8'h06, 32'h21303031, 4);
		i_host.send_byte(8'h06);
		// a command before the host acknowledges is ignored
		frame(8'h31, 8'h20, 8'h45, 8'h01, 2, 8'h00);
		e[0] = e[0] + 1;
		frame(8'h31, 8'h20, 8'h45, 8'h02, 2, 8'h00);
		check({7'h00, i_host.got_q.size() == 0}, 8'h01);
		i_host.send_byte(8'h06);
		tend("ignored");
		print_verdict;
	end
endmodule // pump_serial_command_timing_tb
`default_nettype wire
